//--- hw/sec_pkg.sv
// Purpose: shared constants and types for the sine encoder capture block
// Assumes: 50 MHz clk, AXI4-Lite register access, 32-bit data
// Notes:   register offsets are byte addresses of aligned words
package sec_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_BIAS    = 8'h04;
   localparam logic [7:0] OFS_PHASE   = 8'h08;
   localparam logic [7:0] OFS_SERVO   = 8'h0c;
   localparam logic [7:0] OFS_TRIG    = 8'h10;
   localparam logic [7:0] OFS_MAG     = 8'h14;
   localparam logic [7:0] OFS_STATUS  = 8'h18;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h1c;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h24;
   // ----------------------------------------------------------------
   // control fields and reset values
   // ----------------------------------------------------------------
   localparam int          CTRL_ATAN_BIT  = 0;
   localparam int          CTRL_TSEL_LSB  = 1;
   localparam int          CTRL_DIR_BIT   = 3;
   localparam int          CTRL_TRIG_LSB  = 4;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0010;
   localparam logic [31:0] BIAS_RST       = 32'h0000_0000;
   localparam int          STAT_LOSS_BIT  = 31;
   localparam int          STAT_TRIG_BIT  = 0;
   localparam int          IRQ_W          = 3;
   localparam int          IRQ_TRIG       = 0;
   localparam int          IRQ_LOSS       = 1;
   localparam int          IRQ_PHASE      = 2;
   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int          ATAN_FRAC_W   = 12;
   localparam int          TRIG_FRAC_W   = 8;
   localparam int          ANGLE_W       = 14;
   localparam int          MAG_W         = 16;
   localparam int          LOSS_TOP_W    = 4;
   localparam logic [11:0] HALF_ATAN     = 12'h800;
   localparam logic [7:0]  HALF_TIMER    = 8'h80;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   // trigger edge choices
   typedef enum logic [1:0] {SEC_TRG_RISE, SEC_TRG_FALL, SEC_TRG_BOTH, SEC_TRG_OFF} sec_trg_e;
   // one converter sample pair
   typedef struct packed {
      logic        valid;
      logic [15:0] sine;
      logic [15:0] cosine;
   } sec_conv_s;
endpackage : sec_pkg

//--- hw/sec_magnitude.sv
// Purpose: signal magnitude and loss flag from converter samples
// Assumes: signed 16-bit sine and cosine samples
// Notes:   result updates one cycle after each valid sample pair
`timescale 1ns/1ps
`default_nettype none
module sec_magnitude
   import sec_pkg::*;
(
   input  wire logic              clk,        // system clock
   input  wire logic              srst,       // sync reset, high
   input  wire sec_pkg::sec_conv_s sample,    // converter pair
   output logic [15:0]            mag_ff,     // magnitude value
   output logic                   loss_ff     // loss flag, high true
);
   logic signed [31:0] sq_sin;
   logic signed [31:0] sq_cos;
   logic        [32:0] sum;
   logic        [15:0] nxt_mag;
   logic               nxt_loss;

   // ----------------------------------------------------------------
   // sum of squares
   // ----------------------------------------------------------------
   // squares summed
   always_comb
   begin
      sq_sin   = $signed(sample.sine) * $signed(sample.sine);
      sq_cos   = $signed(sample.cosine) * $signed(sample.cosine);
      sum      = {1'b0, sq_sin} + {1'b0, sq_cos};
      nxt_mag  = mag_ff;
      nxt_loss = loss_ff;
      if (sample.valid)
      begin
         nxt_mag  = sum[31:16];
         nxt_loss = (sum[31:32-LOSS_TOP_W] == '0);
      end
   end

   // loss high at reset: a dead encoder never reads good
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mag_ff  <= 16'h0000;
         loss_ff <= 1'b1;
      end
      else
      begin
         mag_ff  <= nxt_mag;
         loss_ff <= nxt_loss;
      end
   end
endmodule : sec_magnitude
`default_nettype wire

//--- hw/sec_atan.sv
// Purpose: iterative cordic arctangent of bias-corrected samples
// Assumes: signed 16-bit samples, one start at a time
// Notes:   answer after ANGLE_W+1 cycles; a start while busy is dropped
`timescale 1ns/1ps
`default_nettype none
module sec_atan
   import sec_pkg::*;
(
   input  wire logic              clk,        // system clock
   input  wire logic              srst,       // sync reset, high
   input  wire sec_pkg::sec_conv_s sample,    // raw converter pair
   input  wire logic [31:0]       bias,       // cos [31:16], sin [15:0]
   output logic [13:0]            angle_ff    // angle, full turn = 2^14
);
   typedef enum {SEC_IDLE, SEC_RUN} sec_st_e;
   sec_st_e            st_ff, nxt_st;
   logic signed [19:0] x_ff, y_ff, nxt_x, nxt_y, xs, ys, sx, sy;
   logic        [13:0] z_ff, nxt_z, nxt_angle;
   logic        [3:0]  i_ff, nxt_i;

   // arctan of 2^-i in units of 2^-14 turn
   function automatic logic [13:0] sec_atan_step(input logic [3:0] i);
      case (i)
         4'd0:    sec_atan_step = 14'h0800;
         4'd1:    sec_atan_step = 14'h04b9;
         4'd2:    sec_atan_step = 14'h027f;
         4'd3:    sec_atan_step = 14'h0144;
         4'd4:    sec_atan_step = 14'h00a3;
         4'd5:    sec_atan_step = 14'h0051;
         4'd6:    sec_atan_step = 14'h0029;
         4'd7:    sec_atan_step = 14'h0014;
         4'd8:    sec_atan_step = 14'h000a;
         4'd9:    sec_atan_step = 14'h0005;
         4'd10:   sec_atan_step = 14'h0003;
         4'd11:   sec_atan_step = 14'h0001;
         4'd12:   sec_atan_step = 14'h0001;
         default: sec_atan_step = 14'h0000;
      endcase
   endfunction : sec_atan_step

   // ----------------------------------------------------------------
   // vectoring cordic
   // ----------------------------------------------------------------
   always_comb
   begin
      ys        = 20'($signed(sample.sine)) + 20'($signed(bias[15:0]));
      xs        = 20'($signed(sample.cosine)) + 20'($signed(bias[31:16]));
      sx        = x_ff >>> i_ff;
      sy        = y_ff >>> i_ff;
      nxt_st    = st_ff;
      nxt_x     = x_ff;
      nxt_y     = y_ff;
      nxt_z     = z_ff;
      nxt_i     = i_ff;
      nxt_angle = angle_ff;
      case (st_ff)
         SEC_IDLE:
         begin
            if (sample.valid)
            begin
               // left half plane pre-rotated by half a turn
               nxt_x  = xs[19] ? -xs : xs;
               nxt_y  = xs[19] ? -ys : ys;
               nxt_z  = xs[19] ? 14'h2000 : 14'h0000;
               nxt_i  = 4'd0;
               nxt_st = SEC_RUN;
            end
         end
         SEC_RUN:
         begin
            if (y_ff[19])
            begin
               nxt_x = x_ff - sy;
               nxt_y = y_ff + sx;
               nxt_z = z_ff - sec_atan_step(i_ff);
            end
            else
            begin
               nxt_x = x_ff + sy;
               nxt_y = y_ff - sx;
               nxt_z = z_ff + sec_atan_step(i_ff);
            end
            nxt_i = i_ff + 4'd1;
            if (i_ff == 4'(ANGLE_W - 1))
            begin
               nxt_angle = nxt_z;
               nxt_st    = SEC_IDLE;
            end
         end
         default: nxt_st = SEC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_ff    <= SEC_IDLE;
         x_ff     <= '0;
         y_ff     <= '0;
         z_ff     <= '0;
         i_ff     <= '0;
         angle_ff <= '0;
      end
      else
      begin
         st_ff    <= nxt_st;
         x_ff     <= nxt_x;
         y_ff     <= nxt_y;
         z_ff     <= nxt_z;
         i_ff     <= nxt_i;
         angle_ff <= nxt_angle;
      end
   end
endmodule : sec_atan
`default_nettype wire

//--- hw/sec_top.sv
// Purpose: sine encoder position capture and signal loss detection
// Assumes: all inputs synchronous to clk; x4 quadrature decode
// Notes:   AXI4-Lite slave, one outstanding read and one write
`timescale 1ns/1ps
`default_nettype none
module sec_top
   import sec_pkg::*;
#(
   parameter int CNT_W = 24                   // whole-count width
)
(
   input  wire logic              clk,            // 50 MHz clock
   input  wire logic              srst,           // sync reset, high
   input  wire logic              quad_a,         // squared-up sine
   input  wire logic              quad_b,         // squared-up cosine
   input  wire logic              phase_strobe,   // phase clock pulse
   input  wire logic              servo_strobe,   // servo clock pulse
   input  wire logic              trigger_in,     // capture trigger
   input  wire sec_pkg::sec_conv_s encoder_converter_sample, // adc pair
   output logic                   irq,            // level interrupt
   input  wire logic [7:0]        s_axi_awaddr,   // write address
   input  wire logic              s_axi_awvalid,  // write address valid
   output logic                   s_axi_awready,  // write address ready
   input  wire logic [31:0]       s_axi_wdata,    // write data
   input  wire logic [3:0]        s_axi_wstrb,    // write strobes
   input  wire logic              s_axi_wvalid,   // write data valid
   output logic                   s_axi_wready,   // write data ready
   output logic [1:0]             s_axi_bresp,    // write response
   output logic                   s_axi_bvalid,   // response valid
   input  wire logic              s_axi_bready,   // response ready
   input  wire logic [7:0]        s_axi_araddr,   // read address
   input  wire logic              s_axi_arvalid,  // read address valid
   output logic                   s_axi_arready,  // read address ready
   output logic [31:0]            s_axi_rdata,    // read data
   output logic [1:0]             s_axi_rresp,    // read response
   output logic                   s_axi_rvalid,   // read valid
   input  wire logic              s_axi_rready    // read ready
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0]      ctrl_ff, nxt_ctrl, bias_ff, nxt_bias;
   logic [IRQ_W-1:0] irq_st_ff, nxt_irq_st, irq_en_ff, nxt_irq_en, ev;
   logic [31:0]      phase_ff, nxt_phase, servo_ff, nxt_servo;
   logic [31:0]      trig_ff, nxt_trig;
   logic             trig_seen_ff, nxt_trig_seen;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [1:0]       ab_ff;
   logic             trig_prev_ff, loss_prev_ff;
   logic [15:0]      period_ff, nxt_period, since_ff, nxt_since;
   logic [23:0]      quot;
   logic [7:0]       tfrac;
   logic [11:0]      afrac;
   logic [13:0]      angle;
   logic [15:0]      mag;
   logic             loss, step, up, fire;
   sec_trg_e         trg_sel;
   logic             bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0]       bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0]      rdata_ff, nxt_rdata;
   logic             wr_go, rd_go;

   // mapped offsets, read and write decode
   function automatic logic sec_mapped(input logic [7:0] a);
      sec_mapped = (a[1:0] == 2'b00) && (a <= OFS_IRQ_EN);
   endfunction : sec_mapped

   // byte-lane write merge
   function automatic logic [31:0] sec_merge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
      for (int k = 0; k < 4; k++)
      begin
         sec_merge[8*k +: 8] = s[k] ? d[8*k +: 8] : old[8*k +: 8];
      end
   endfunction : sec_merge

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   sec_atan u_atan (
      .clk      (clk),
      .srst     (srst),
      .sample   (encoder_converter_sample),
      .bias     (bias_ff),
      .angle_ff (angle)
   );

   sec_magnitude u_mag (
      .clk     (clk),
      .srst    (srst),
      .sample  (encoder_converter_sample),
      .mag_ff  (mag),
      .loss_ff (loss)
   );

   // ----------------------------------------------------------------
   // quadrature counter and 1/T timer
   // ----------------------------------------------------------------
   // x4 decode: one line changing is a count
   always_comb
   begin
      step       = (quad_a ^ ab_ff[1]) ^ (quad_b ^ ab_ff[0]);
      up         = (ab_ff[1] ^ quad_b) ^ ctrl_ff[CTRL_DIR_BIT];
      nxt_cnt    = cnt_ff;
      nxt_period = period_ff;
      nxt_since  = (since_ff == 16'hffff) ? since_ff : since_ff + 16'd1;
      if (step)
      begin
         nxt_cnt    = up ? cnt_ff + 1'b1 : cnt_ff - 1'b1;
         nxt_period = nxt_since;
         nxt_since  = 16'h0000;
      end
   end

   // fraction saturates below one count at low speed
   // shared half-count offset
   always_comb
   begin
      quot  = (period_ff == 16'h0000) ? 24'hffffff
                                      : {since_ff, 8'h00} / {8'h00, period_ff};
      tfrac = ((quot > 24'h0000ff) ? 8'hff : quot[7:0]) + HALF_TIMER;
      afrac = angle[ATAN_FRAC_W-1:0] + HALF_ATAN;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_ff    <= '0;
         ab_ff     <= 2'b00;
         period_ff <= 16'h0000;
         since_ff  <= 16'h0000;
      end
      else
      begin
         cnt_ff    <= nxt_cnt;
         ab_ff     <= {quad_a, quad_b};
         period_ff <= nxt_period;
         since_ff  <= nxt_since;
      end
   end

   // ----------------------------------------------------------------
   // capture words
   // ----------------------------------------------------------------
   always_comb
   begin
      trg_sel   = sec_trg_e'(ctrl_ff[CTRL_TRIG_LSB +: 2]);
      case (trg_sel)
         SEC_TRG_RISE: fire = trigger_in & ~trig_prev_ff;
         SEC_TRG_FALL: fire = ~trigger_in & trig_prev_ff;
         SEC_TRG_BOTH: fire = trigger_in ^ trig_prev_ff;
         default:      fire = 1'b0;
      endcase
      nxt_phase     = phase_ff;
      nxt_servo     = servo_ff;
      nxt_trig      = trig_ff;
      nxt_trig_seen = trig_seen_ff;
      if (phase_strobe)
      begin
         nxt_phase = ctrl_ff[CTRL_ATAN_BIT] ? {cnt_ff[19:0], afrac}
                                            : {cnt_ff[23:0], HALF_TIMER};
      end
      if (servo_strobe)
      begin
         nxt_servo = ctrl_ff[CTRL_ATAN_BIT] ? {cnt_ff[19:0], afrac}
                                            : {cnt_ff[23:0], HALF_TIMER};
      end
      if (fire)
      begin
         nxt_trig      = {cnt_ff[23:0],
                          (ctrl_ff[CTRL_TSEL_LSB +: 2] == 2'b00) ? tfrac : 8'h00};
         nxt_trig_seen = 1'b1;
      end
      else if (rd_go && s_axi_araddr == OFS_TRIG)
      begin
         nxt_trig_seen = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phase_ff     <= 32'h0000_0000;
         servo_ff     <= 32'h0000_0000;
         trig_ff      <= 32'h0000_0000;
         trig_seen_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
         loss_prev_ff <= 1'b1;
      end
      else
      begin
         phase_ff     <= nxt_phase;
         servo_ff     <= nxt_servo;
         trig_ff      <= nxt_trig;
         trig_seen_ff <= nxt_trig_seen;
         trig_prev_ff <= trigger_in;
         loss_prev_ff <= loss;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave and registers
   // ----------------------------------------------------------------
   // address and data are taken together; simpler than two skid paths
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign rd_go         = s_axi_arvalid & ~rvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign irq           = |(irq_st_ff & irq_en_ff);

   always_comb
   begin
      ev             = '0;
      ev[IRQ_TRIG]   = fire;
      ev[IRQ_LOSS]   = loss & ~loss_prev_ff;
      ev[IRQ_PHASE]  = phase_strobe;
      nxt_ctrl       = ctrl_ff;
      nxt_bias       = bias_ff;
      nxt_irq_en     = irq_en_ff;
      nxt_irq_st     = irq_st_ff;
      nxt_bvalid     = bvalid_ff & ~s_axi_bready;
      nxt_bresp      = bresp_ff;
      nxt_rvalid     = rvalid_ff & ~s_axi_rready;
      nxt_rresp      = rresp_ff;
      nxt_rdata      = rdata_ff;
      if (wr_go)
      begin
         nxt_bvalid = 1'b1;
         nxt_bresp  = sec_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_awaddr)
            OFS_CTRL:    nxt_ctrl   = sec_merge(ctrl_ff, s_axi_wdata, s_axi_wstrb);
            OFS_BIAS:    nxt_bias   = sec_merge(bias_ff, s_axi_wdata, s_axi_wstrb);
            OFS_IRQ_EN:  nxt_irq_en = s_axi_wstrb[0] ? s_axi_wdata[IRQ_W-1:0] : irq_en_ff;
            OFS_IRQ_CLR: nxt_irq_st = s_axi_wstrb[0] ? irq_st_ff & ~s_axi_wdata[IRQ_W-1:0]
                                                     : irq_st_ff;
            default:     nxt_ctrl   = ctrl_ff;
         endcase
      end
      // new events win over a clear in the same cycle
      nxt_irq_st = nxt_irq_st | ev;
      if (rd_go)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = sec_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_CTRL:   nxt_rdata = ctrl_ff;
            OFS_BIAS:   nxt_rdata = bias_ff;
            OFS_PHASE:  nxt_rdata = phase_ff;
            OFS_SERVO:  nxt_rdata = servo_ff;
            OFS_TRIG:   nxt_rdata = trig_ff;
            OFS_MAG:    nxt_rdata = {16'h0000, mag};
            OFS_STATUS: nxt_rdata = {loss, 30'h0, trig_seen_ff};
            OFS_IRQ_ST: nxt_rdata = {{(32-IRQ_W){1'b0}}, irq_st_ff};
            OFS_IRQ_EN: nxt_rdata = {{(32-IRQ_W){1'b0}}, irq_en_ff};
            default:    nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_ff   <= CTRL_RST;
         bias_ff   <= BIAS_RST;
         irq_en_ff <= '0;
         irq_st_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         ctrl_ff   <= nxt_ctrl;
         bias_ff   <= nxt_bias;
         irq_en_ff <= nxt_irq_en;
         irq_st_ff <= nxt_irq_st;
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff  <= nxt_rresp;
         rdata_ff  <= nxt_rdata;
      end
   end
endmodule : sec_top
`default_nettype wire

//--- tb/sec_enc_model.sv
// Purpose: encoder model, quadrature lines and converter pairs
// Assumes: driven by the bench's task calls
// Notes:   each step is one count
`timescale 1ns/1ps
`default_nettype none
module sec_enc_model
   import sec_pkg::*;
(
   input  wire logic          clk, // system clock
   output logic               qa,  // quadrature line a
   output logic               qb,  // quadrature line b
   output sec_pkg::sec_conv_s smp  // converter pair
);
   // lines idle low, no pair offered
   initial
   begin
      qa = 1'b0;
      qb = 1'b0;
      smp = '0;
   end
   // forward count, one line at a time
   task automatic step();
      @(posedge clk);
      if (qa == qb)
         qb <= ~qb;
      else
         qa <= ~qa;
   endtask : step
   // one-cycle pair, then inverted data
   task automatic send(input logic [15:0] s, input logic [15:0] c);
      @(posedge clk);
      smp <= {1'b1, s, c};
      @(posedge clk);
      smp <= {1'b0, ~s, ~c};
   endtask : send
endmodule : sec_enc_model
`default_nettype wire

//--- tb/sec_top_properties.sv
// Purpose: bus timing and magnitude checks at the top ports
// Assumes: one read and one write at a time
// Notes:   magnitude re-modelled to judge reads
`timescale 1ns/1ps
`default_nettype none
module sec_top_properties
   import sec_pkg::*;
(
   input wire logic               clk, // clock
   input wire logic               srst, // reset
   input wire sec_pkg::sec_conv_s encoder_converter_sample, // pair
   input wire logic [7:0]         s_axi_awaddr, // write addr
   input wire logic               s_axi_awvalid, // aw valid
   input wire logic               s_axi_wvalid, // w valid
   input wire logic               s_axi_bvalid, // b valid
   input wire logic               s_axi_bready, // b ready
   input wire logic [1:0]         s_axi_bresp, // b resp
   input wire logic [7:0]         s_axi_araddr, // read addr
   input wire logic               s_axi_arvalid, // ar valid
   input wire logic               s_axi_rvalid, // r valid
   input wire logic               s_axi_rready, // r ready
   input wire logic [31:0]        s_axi_rdata, // r data
   input wire logic [1:0]         s_axi_rresp // r resp
);
   logic signed [31:0] sn, cs;
   logic [31:0]        sum;
   logic [15:0]        mag_ff, nxt_mag, rmag_ff, nxt_rmag;
   // expected magnitude, frozen at read
   always_comb
   begin
      sn = $signed(encoder_converter_sample.sine);
      cs = $signed(encoder_converter_sample.cosine);
      sum = sn * sn + cs * cs;
      nxt_mag = encoder_converter_sample.valid ? sum[31:16] : mag_ff;
      nxt_rmag = (s_axi_arvalid && !s_axi_rvalid) ? mag_ff : rmag_ff;
   end
   always_ff @(posedge clk)
   begin
      mag_ff <= srst ? 16'h0 : nxt_mag;
      rmag_ff <= nxt_rmag;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |=> s_axi_bvalid) else $error("write not answered");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read not answered");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rd_err_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > OFS_IRQ_EN
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read accepted");
   wr_err_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      && s_axi_awaddr > OFS_IRQ_EN |=> s_axi_bresp == RESP_SLVERR) else $error("bad write accepted");
   mag_read_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == OFS_MAG
      |=> s_axi_rdata[15:0] == rmag_ff) else $error("magnitude wrong");
   loss_read_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == OFS_STATUS
      |=> s_axi_rdata[31] == (rmag_ff[15:12] == 4'h0)) else $error("loss flag wrong");
endmodule : sec_top_properties
bind sec_top sec_top_properties u_sec_top_properties (.clk, .srst, .encoder_converter_sample,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

//--- tb/sec_top_test.sv
// Purpose: self-checking bench for sec_top
// Assumes: model drives lines and pairs
// Notes:   timer path off for the trigger check
`timescale 1ns/1ps
`default_nettype none
module sec_top_test;
   import sec_pkg::*;
   typedef struct packed {logic [15:0] s, c, mag; logic loss;} sec_row_s;
   logic        clk = 1'b0, srst = 1'b1, quad_a, quad_b, irq;
   logic        phase_strobe = 1'b0, servo_strobe = 1'b0, trigger_in = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   sec_conv_s   encoder_converter_sample;
   int          fails = 0, num_checks = 0;
   // pairs either side of the loss boundary
   sec_row_s    rows [5] = '{'{16'h3fff, 16'h0, 16'h0fff, 1'b1}, '{16'h4000, 16'h0, 16'h1000, 1'b0},
      '{16'h0100, 16'h0100, 16'h0002, 1'b1}, '{16'hc000, 16'hc000, 16'h2000, 1'b0},
      '{16'h8000, 16'h0, 16'h4000, 1'b0}};
   sec_top u_sec_top (.clk, .srst, .quad_a, .quad_b, .phase_strobe, .servo_strobe,
      .trigger_in, .encoder_converter_sample, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   sec_enc_model u_sec_enc_model (.clk, .qa(quad_a), .qb(quad_b), .smp(encoder_converter_sample));
   always #10 clk = ~clk;
   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // spent wait bound ends the run
   task automatic guard(input int n);
      if (n >= 50)
      begin
         fails++;
         $display("MISMATCH %0t bus wait ran out", $time);
         close_out();
      end
   endtask : guard
   // entry edge first: no strobe set twice
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n = 0;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
      do @(posedge clk); while ((s_axi_awready & s_axi_wready) !== 1'b1 && ++n < 50);
      {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1 && ++n < 50);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      guard(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n = 0;
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do @(posedge clk); while (s_axi_arready !== 1'b1 && ++n < 50);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1 && ++n < 50);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      guard(n);
   endtask : rd
   // both strobes, once decode settles
   task automatic strobe();
      repeat (3) @(posedge clk);
      phase_strobe <= 1'b1;
      servo_strobe <= 1'b1;
      @(posedge clk);
      phase_strobe <= 1'b0;
      servo_strobe <= 1'b0;
   endtask : strobe
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_CTRL, d, r);
      chk(d, CTRL_RST);
      rd(OFS_STATUS, d, r);
      chk(32'(d[31]), 32'h1);
      wr(OFS_BIAS, 32'h1234_5678, r);
      rd(OFS_BIAS, d, r);
      chk(d, 32'h1234_5678);
      foreach (rows[i])
      begin
         u_sec_enc_model.send(rows[i].s, rows[i].c);
         rd(OFS_MAG, d, r);
         chk(32'(d[15:0]), 32'(rows[i].mag));
         rd(OFS_STATUS, d, r);
         chk(32'(d[31]), 32'(rows[i].loss));
      end
      // arctan off: half-count fraction
      repeat (5) u_sec_enc_model.step();
      strobe();
      rd(OFS_PHASE, d, r);
      chk(d, {24'd5, 8'h80});
      rd(OFS_SERVO, d, r);
      chk(d, {24'd5, 8'h80});
      // arctan on, timer path off, falling trigger
      wr(OFS_BIAS, 32'h0, r);
      wr(OFS_CTRL, 32'h13, r);
      u_sec_enc_model.send(16'h0, 16'h4000);
      repeat (20) @(posedge clk);
      strobe();
      rd(OFS_PHASE, d, r);
      chk(32'(d[31:12]), 32'd5);
      wr(OFS_IRQ_EN, 32'h1, r);
      trigger_in <= 1'b0;
      // later counts must not reach the word
      repeat (3) u_sec_enc_model.step();
      rd(OFS_TRIG, d, r);
      chk(d, {24'd5, 8'h00});
      chk(32'(irq), 32'h1);
      wr(OFS_IRQ_EN, 32'h0, r);
      chk(32'(irq), 32'h0);
      wr(OFS_IRQ_EN, 32'h1, r);
      wr(OFS_IRQ_CLR, 32'h1, r);
      chk(32'(irq), 32'h0);
      rd(8'h40, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(8'h40, 32'h1, r);
      chk(32'(r), 32'(RESP_SLVERR));
      close_out();
   end
endmodule : sec_top_test
`default_nettype wire
